// ### src/sensor_fifo_defines.vh
// register offsets, field positions, mode codes and sizes for the sensor fifo readout
`ifndef SENSOR_FIFO_DEFINES_VH
`define SENSOR_FIFO_DEFINES_VH
`define ADDR_PIN1_ROUTE 8'h0d
`define ADDR_PIN2_ROUTE 8'h0e
`define ADDR_WATERMARK_LOW 8'h06
`define ADDR_WATERMARK_HIGH 8'h07
`define ADDR_BUFFER_MODE 8'h0a
`define ADDR_COUNT_LOW 8'h3a
`define ADDR_FLAGS_COUNT_HIGH 8'h3b
`define ADDR_PATTERN_LOW 8'h3c
`define ADDR_PATTERN_HIGH 8'h3d
`define ADDR_OUT_LOW 8'h3e
`define ADDR_OUT_HIGH 8'h3f
`define BIT_WATERMARK 7
`define BIT_OVERRUN 6
`define BIT_FULL 5
`define BIT_EMPTY 4
`define ROUTE_BIT_WATERMARK 3
`define ROUTE_BIT_OVERRUN 4
`define ROUTE_BIT_FULL 5
`define MODE_BYPASS 3'h0
`define MODE_STOP_FULL 3'h1
`define MODE_CONT_THEN_STOP 3'h3
`define MODE_BYPASS_THEN_CONT 3'h4
`define MODE_CONTINUOUS 3'h6
`define BUFFER_DEPTH 4096
`define COUNT_WIDTH 12
`define PATTERN_WIDTH 10
`define PATTERN_PERIOD 10'h006
`endif

// ### src/fifo_word_store.v
// flip-flop word storage with one write and one read port
`timescale 1ns/1ns
module fifo_word_store #(
  parameter WIDTH = 16,
  parameter DEPTH = 4096,
  parameter AW = 12
) (
  input wire sys_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_reg[rd_addr];
endmodule // fifo_word_store

// ### src/sensor_fifo_status_readout.v
// sensor sample fifo: status flags, unread count, pattern index and byte-pair readout
`timescale 1ns/1ns
`include "sensor_fifo_defines.vh"
module sensor_fifo_status_readout #(
  parameter DEPTH = `BUFFER_DEPTH,
  parameter AW = `COUNT_WIDTH,
  parameter [9:0] PATTERN_PERIOD = `PATTERN_PERIOD
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire sample_valid,
  input wire [15:0] sample_data,
  input wire trigger_event,
  output reg int1_out,
  output reg int2_out
);
  reg [7:0] pin1_route_register;
  reg [7:0] pin2_route_register;
  reg [2:0] buffer_mode_register;
  reg [11:0] watermark_level_reg;
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] stored_reg;
  reg overrun_reg;
  reg stopped_reg;
  reg trig_seen_reg;
  reg [9:0] pattern_reg;
  wire [15:0] head_word;
  wire [31:0] depth_full = DEPTH;
  wire [AW:0] depth_w = depth_full[AW:0];
  // zero-extended copy so the 12-bit count field works for depths up to 4096
  wire [31:0] stored_wide = {{(31-AW){1'b0}}, stored_reg};

  // mode decode, shared by write acceptance and overwrite choice
  function [1:0] mode_behaviour;
    input [2:0] mode;
    input trig;
    begin
      case (mode)
        `MODE_STOP_FULL: mode_behaviour = 2'h1;
        `MODE_CONTINUOUS: mode_behaviour = 2'h2;
        `MODE_CONT_THEN_STOP: mode_behaviour = trig ? 2'h1 : 2'h2;
        `MODE_BYPASS_THEN_CONT: mode_behaviour = trig ? 2'h2 : 2'h0;
        default: mode_behaviour = 2'h0;
      endcase
    end
  endfunction

  wire [1:0] behaviour = mode_behaviour(buffer_mode_register, trig_seen_reg);
  wire collecting = (behaviour != 2'h0);
  wire overwrite_ok = (behaviour == 2'h2);
  wire is_full = (stored_reg == depth_w);
  wire pop = reg_rd && (reg_addr == `ADDR_OUT_HIGH) && (stored_reg != {(AW+1){1'b0}});
  // in stop-when-full the buffer freezes once full, even if later read
  wire accept = sample_valid && collecting && !stopped_reg && (!is_full || overwrite_ok || pop);
  wire overwrite = accept && is_full && !pop;
  wire bypass_now = (buffer_mode_register == `MODE_BYPASS);

  fifo_word_store #(.WIDTH(16), .DEPTH(DEPTH), .AW(AW)) store_u (
    .sys_clk(sys_clk),
    .wr_en(accept),
    .wr_addr(wr_ptr_reg),
    .wr_data(sample_data),
    .rd_addr(rd_ptr_reg),
    .rd_data(head_word)
  );

  // configuration registers
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin1_route_register <= 8'h00;
      pin2_route_register <= 8'h00;
      buffer_mode_register <= 3'h0;
      watermark_level_reg <= 12'h000;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_PIN1_ROUTE: pin1_route_register <= reg_wdata;
        `ADDR_PIN2_ROUTE: pin2_route_register <= reg_wdata;
        `ADDR_BUFFER_MODE: buffer_mode_register <= reg_wdata[2:0];
        `ADDR_WATERMARK_LOW: watermark_level_reg[7:0] <= reg_wdata;
        `ADDR_WATERMARK_HIGH: watermark_level_reg[11:8] <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // buffer pointers, fill level and flags move only on writes, reads and triggers, and are cleared while in bypass mode
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      stored_reg <= {(AW+1){1'b0}};
      overrun_reg <= 1'b0;
      stopped_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
      pattern_reg <= 10'h000;
    end else if (bypass_now) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      stored_reg <= {(AW+1){1'b0}};
      overrun_reg <= 1'b0;
      stopped_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
      pattern_reg <= 10'h000;
    end else begin
      if (trigger_event) begin
        trig_seen_reg <= 1'b1;
      end
      if (accept) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      // overwriting drops the oldest word, so the read side steps past it
      if (pop || overwrite) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        pattern_reg <= (pattern_reg == PATTERN_PERIOD - 10'h001) ? 10'h000 : pattern_reg + 10'h001;
      end
      if (accept && !pop && !overwrite) begin
        stored_reg <= stored_reg + 1'b1;
      end else if (pop && !accept) begin
        stored_reg <= stored_reg - 1'b1;
      end
      if (overwrite) begin
        overrun_reg <= 1'b1;
      end else if (pop) begin
        overrun_reg <= 1'b0;
      end
      if (accept && behaviour == 2'h1 && stored_reg == depth_w - 1'b1) begin
        stopped_reg <= 1'b1;
      end
    end
  end

  // full warns that the next stored sample replaces the oldest; count still shows depth-1 one step earlier
  wire full_flag = is_full && !bypass_now;
  wire [11:0] unread_word_count = (full_flag || bypass_now) ? 12'h000 : stored_wide[11:0];
  wire empty_flag = (stored_reg == {(AW+1){1'b0}}) || bypass_now;
  wire watermark_flag = !bypass_now && (stored_wide >= {20'h00000, watermark_level_reg}) &&
    (watermark_level_reg != 12'h000);
  wire [7:0] status_byte = {watermark_flag, overrun_reg && !bypass_now, full_flag, empty_flag,
    unread_word_count[11:8]};

  // interrupt pins, registered from flag and route bits
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int1_out <= 1'b0;
      int2_out <= 1'b0;
    end else begin
      int1_out <= (watermark_flag && pin1_route_register[`ROUTE_BIT_WATERMARK]) ||
        (overrun_reg && pin1_route_register[`ROUTE_BIT_OVERRUN]) ||
        (full_flag && pin1_route_register[`ROUTE_BIT_FULL]);
      int2_out <= (watermark_flag && pin2_route_register[`ROUTE_BIT_WATERMARK]) ||
        (overrun_reg && pin2_route_register[`ROUTE_BIT_OVERRUN]) ||
        (full_flag && pin2_route_register[`ROUTE_BIT_FULL]);
    end
  end

  // read data registered; an empty buffer returns zeros
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_PIN1_ROUTE: reg_rdata <= pin1_route_register;
        `ADDR_PIN2_ROUTE: reg_rdata <= pin2_route_register;
        `ADDR_BUFFER_MODE: reg_rdata <= {5'h00, buffer_mode_register};
        `ADDR_WATERMARK_LOW: reg_rdata <= watermark_level_reg[7:0];
        `ADDR_WATERMARK_HIGH: reg_rdata <= {4'h0, watermark_level_reg[11:8]};
        `ADDR_COUNT_LOW: reg_rdata <= unread_word_count[7:0];
        `ADDR_FLAGS_COUNT_HIGH: reg_rdata <= status_byte;
        `ADDR_PATTERN_LOW: reg_rdata <= pattern_reg[7:0];
        `ADDR_PATTERN_HIGH: reg_rdata <= {6'h00, pattern_reg[9:8]};
        `ADDR_OUT_LOW: reg_rdata <= empty_flag ? 8'h00 : head_word[7:0];
        `ADDR_OUT_HIGH: reg_rdata <= empty_flag ? 8'h00 : head_word[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // sensor_fifo_status_readout

// ### sim/fifo_readout_checker_assertions.sv
// assertion checker bound to the fifo readout top
`timescale 1ns/1ns
module fifo_readout_checker (
  input wire sys_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire int1_out,
  input wire int2_out
);
  reg [7:0] addr_reg;
  reg [2:0] mode_reg;
  reg [2:0] route_reg;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= 8'h00;
      mode_reg <= 3'h0;
      route_reg <= 3'h0;
    end else begin
      if (reg_rd) addr_reg <= reg_addr;
      if (reg_wr && reg_addr == 8'h0a) mode_reg <= reg_wdata[2:0];
      if (reg_wr && reg_addr == 8'h0d) route_reg <= reg_wdata[5:3];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("rdata moved");
  a_pattern_high_zero: assert property (addr_reg == 8'h3d |-> reg_rdata[7:2] == 6'h00)
    else $error("pattern high bits");
  a_full_count_zero: assert property (addr_reg == 8'h3b && reg_rdata[5] |-> reg_rdata[3:0] == 4'h0)
    else $error("count while full");
  a_empty_flags_clear: assert property (addr_reg == 8'h3b && reg_rdata[4] |-> reg_rdata[6:0] == 7'h10)
    else $error("empty with flags");
  // one spare cycle lets the clear land after a mode write
  a_bypass_status: assert property ((mode_reg == 3'h0)[*2] ##0 (reg_rd && reg_addr == 8'h3b) |=> reg_rdata == 8'h10)
    else $error("bypass status");
  a_bypass_count: assert property ((mode_reg == 3'h0)[*2] ##0 (reg_rd && reg_addr == 8'h3a) |=> reg_rdata == 8'h00)
    else $error("bypass count");
  a_bypass_pins_quiet: assert property ((mode_reg == 3'h0)[*3] |-> !int1_out && !int2_out)
    else $error("pin in bypass");
  a_route_off_quiet: assert property ((route_reg == 3'h0)[*2] |-> !int1_out)
    else $error("unrouted pin");
endmodule // fifo_readout_checker
bind sensor_fifo_status_readout fifo_readout_checker chk_i (.sys_clk, .sys_rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .int1_out, .int2_out);

// ### sim/host_model.sv
// host model issuing register reads and writes
`timescale 1ns/1ns
module host_model (
  input wire sys_clk,
  input wire [7:0] reg_rdata,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00
);
  task reg_write(input [7:0] a, input [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  // callers take the low byte first, the high byte pops
  task reg_read(input [7:0] a, output [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rdata;
  endtask
endmodule // host_model

// ### sim/testbench.sv
// self-checking bench for the fifo readout
`timescale 1ns/1ns
module testbench;
  localparam DEPTH = 16;
  reg sys_clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0, trigger_event = 1'b0, ovr = 1'b0;
  reg [15:0] sample_data = 16'h0000;
  reg [31:0] lfsr = 32'hedd9;
  reg [7:0] d;
  reg [15:0] q[$];
  wire reg_wr, reg_rd, int1_out, int2_out;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  integer mismatches = 0, check_count = 0, cycles = 0, wm = 4, m;
  always #10 sys_clk = ~sys_clk;
  host_model host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  // a shallow buffer keeps the full and overwrite cases short
  sensor_fifo_status_readout #(.DEPTH(DEPTH), .AW(4)) uut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .sample_valid, .sample_data, .trigger_event, .int1_out, .int2_out);
  function [31:0] lfsr_next(input [31:0] x);
    lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task push(input integer n, input integer md);
    repeat (n) begin
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      sample_data <= lfsr[15:0];
      if (md == 3 || md == 6 || (md == 1 && q.size() < DEPTH)) begin
        if (q.size() == DEPTH) begin
          void'(q.pop_front());
          ovr = 1'b1;
        end
        q.push_back(lfsr[15:0]);
      end
    end
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task set_mode(input integer md);
    host.reg_write(8'h0a, 8'h00);
    q.delete();
    ovr = 1'b0;
    host.reg_write(8'h0a, md[7:0]);
  endtask
  task pop_word;
    host.reg_read(8'h3e, d);
    chk(d, q[0][7:0]);
    host.reg_read(8'h3f, d);
    chk(d, q[0][15:8]);
    void'(q.pop_front());
    ovr = 1'b0;
  endtask
  task check_status;
    host.reg_read(8'h3a, d);
    chk(d, q.size() >= DEPTH ? 8'h00 : 8'(q.size()));
    host.reg_read(8'h3b, d);
    chk(d, {wm <= q.size(), ovr, q.size() >= DEPTH, q.size() == 0, 4'h0});
  endtask
  task print_verdict;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    check_status;
    host.reg_write(8'h06, 8'h04);
    host.reg_write(8'h0d, 8'h08);
    host.reg_write(8'h0e, 8'h20);
    host.reg_read(8'h40, d);
    chk(d, 8'h00);
    set_mode(6);
    push(3, 6);
    check_status;
    push(1, 6);
    check_status;
    chk({6'h00, int2_out, int1_out}, 8'h01);
    pop_word;
    host.reg_read(8'h3c, d);
    chk(d, 8'h01);
    check_status;
    push(DEPTH - 4, 6);
    check_status;
    push(1, 6);
    check_status;
    chk({6'h00, int2_out, int1_out}, 8'h03);
    push(1, 6);
    check_status;
    pop_word;
    pop_word;
    check_status;
    for (m = 0; m < 8; m = m + 1) begin
      set_mode(m);
      push(2, m);
      check_status;
    end
    set_mode(4);
    trigger_event <= 1'b1;
    push(2, 6);
    trigger_event <= 1'b0;
    check_status;
    set_mode(1);
    push(DEPTH + 2, 1);
    check_status;
    pop_word;
    print_verdict;
  end
endmodule // testbench
